//--- pkg/se_i2c_regs.svh
// Constants for the two-wire target port of the security coprocessor.
// Assumes inclusion by bare name; definitions only.
`ifndef SE_I2C_REGS_SVH
`define SE_I2C_REGS_SVH
`define WA_RESET        8'h00
`define WA_SLEEP        8'h01
`define WA_IDLE         8'h02
`define WA_COMMAND      8'h03
`define BUF_BYTES       71
`define ADDR_RESET      7'h60
`define CLK_PERIOD_NS   20
`define WAKE_LOW_NS     60000
`define WAKE_READY_NS   1500000
`define EXEC_NS         2000000
`define WAKE_LOW_CYC    ((`WAKE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_READY_CYC  ((`WAKE_READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXEC_CYC        ((`EXEC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- pkg/se_i2c_pkg.sv
// Types for the two-wire target port.
// Assumes no surroundings beyond the constant header.
package se_i2c_pkg;
  typedef enum logic [2:0] {
    PWR_SLEEP = 3'b000,
    PWR_IDLE  = 3'b001,
    PWR_WAKE  = 3'b010,
    PWR_READY = 3'b011,
    PWR_BUSY  = 3'b100
  } pwr_state_t;

  typedef enum logic [2:0] {
    BUS_FREE  = 3'b000,
    BUS_ADDR  = 3'b001,
    BUS_WORD  = 3'b010,
    BUS_DATA  = 3'b011,
    BUS_READ  = 3'b100,
    BUS_SKIP  = 3'b101
  } bus_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } pins_t;
endpackage : se_i2c_pkg

//--- hw/se_i2c_target.sv
// Two-wire serial target port: wake, bit framing, address match, word
// address decode and command buffer fill. Assumes pins arrive from outside
// the clock domain and that the command engine is modelled by a timer.
`timescale 1ns/10ps
`include "se_i2c_regs.svh"

// Operation
// - Long low data line wakes device; after ready delay it accepts traffic.
// - Asleep, idle or waking, the clock pin is ignored, only wake counts.
// - Woken but unaddressed devices stay idle and never drive the bus.
// - A wake sequence while awake is ignored with no state change.
// - Bit is data level sampled on clock rise; data changes while clock low.
// - Data falling with clock high is a start condition.
// - Data rising with clock high ends transfer; full command starts busy.
// - Receiver pulls data low on ninth clock to acknowledge.
// - Receiver leaves data high on ninth clock to refuse or end.
// - Device only pulls data low through open drain.
// - Address bits 1-7 MSB first must match; eighth bit zero means write.
// - Word address 0x00 clears the buffer address counter.
// - Word address 0x01 sleeps and resets all volatile state; buffer bytes are kept, fill, count and keep flag clear.
// - Word address 0x02 idles and keeps key and seed contents.
// - Word address 0x03 stores following bytes after earlier ones.
// - Buffer is FIFO; first byte is count, extras discarded until done.
// - While executing a read address is not acknowledged.
// - Read address refused when busy, idle or asleep.
// - Bytes past count or past 71 bytes are not acknowledged.
module se_i2c_target
  import se_i2c_pkg::*;
#(
  parameter int WAKE_LOW_CYCLES  = `WAKE_LOW_CYC,
  parameter int WAKE_READY_CYCLES = `WAKE_READY_CYC,
  parameter int EXEC_CYCLES      = `EXEC_CYC,
  parameter int BUF_DEPTH        = `BUF_BYTES
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Programmed bus address
  input  wire logic [6:0] bus_address_in,
  // Buffer contents for the command engine
  output logic [7:0]      buf_data_out [BUF_DEPTH],
  output logic [6:0]      buf_fill_out,
  // Power and activity state
  output logic            awake_out,
  output logic            busy_out,
  output logic            keep_key_seed_out
);

  localparam int CW = 22;

  initial begin
    if (BUF_DEPTH < 2 || BUF_DEPTH > 127 || WAKE_LOW_CYCLES < 1 ||
        WAKE_READY_CYCLES < 1 || EXEC_CYCLES < 1 ||
        WAKE_LOW_CYCLES >= (1 << CW) || WAKE_READY_CYCLES >= (1 << CW) ||
        EXEC_CYCLES >= (1 << CW)) begin
      $error("se_i2c_target: unsupported parameter values");
    end
  end

  // Two-flop synchronisers; stage one read only by stage two
  pins_t meta;
  pins_t sync;
  pins_t prev;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta <= '{scl: 1'b1, sda: 1'b1};
      sync <= '{scl: 1'b1, sda: 1'b1};
      prev <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      meta <= '{scl: scl_in, sda: sda_in};
      sync <= meta;
      prev <= sync;
    end
  end

  // Bus events from synchronised levels
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = sync.scl & ~prev.scl;
  assign scl_fall = ~sync.scl & prev.scl;
  assign start_ev = sync.scl & prev.scl & prev.sda & ~sync.sda;
  assign stop_ev  = sync.scl & prev.scl & ~prev.sda & sync.sda;

  // State
  pwr_state_t       pwr;
  bus_state_t       bus;
  logic [CW-1:0]    timer;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift;
  logic             ack_phase;
  logic             ack_drive;
  logic [6:0]       wr_ptr;
  logic [7:0]       count;
  logic             keep;
  logic [7:0]       buffer [BUF_DEPTH];

  pwr_state_t       next_pwr;
  bus_state_t       next_bus;
  logic [CW-1:0]    next_timer;
  logic [3:0]       next_bit_cnt;
  logic [7:0]       next_shift;
  logic             next_ack_phase;
  logic             next_ack_drive;
  logic [6:0]       next_wr_ptr;
  logic [7:0]       next_count;
  logic             next_keep;
  logic             wr_en;

  // Next-state logic for power, bit framing and buffer fill
  always_comb begin
    logic [7:0] byte_now;
    logic       accept;
    byte_now       = {shift[6:0], sync.sda};
    accept         = 1'b0;
    next_pwr       = pwr;
    next_bus       = bus;
    next_timer     = timer;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_ack_phase = ack_phase;
    next_ack_drive = ack_drive;
    next_wr_ptr    = wr_ptr;
    next_count     = count;
    next_keep      = keep;
    wr_en          = 1'b0;
    case (pwr)
      PWR_SLEEP, PWR_IDLE: begin
        // Clock pin ignored; only a long data low wakes
        next_bus = BUS_FREE;
        next_ack_drive = 1'b0;
        if (sync.sda) begin
          next_timer = '0;
        end else if (timer == CW'(WAKE_LOW_CYCLES)) begin
          next_pwr   = PWR_WAKE;
          next_timer = '0;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      PWR_WAKE: begin
        // Wake-to-ready delay; traffic ignored until it ends
        next_bus = BUS_FREE;
        if (timer == CW'(WAKE_READY_CYCLES - 1)) begin
          next_pwr   = PWR_READY;
          next_timer = '0;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      PWR_BUSY: begin
        // Execution stands in for the command engine; bus ignored
        next_bus = BUS_FREE;
        next_ack_drive = 1'b0;
        if (timer == CW'(EXEC_CYCLES - 1)) begin
          next_pwr    = PWR_READY;
          next_timer  = '0;
          next_wr_ptr = '0;
          next_count  = '0;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      PWR_READY: begin
        // Long data lows while awake change nothing
        if (start_ev) begin
          next_bus       = BUS_ADDR;
          next_bit_cnt   = '0;
          next_ack_phase = 1'b0;
          next_ack_drive = 1'b0;
        end else if (stop_ev) begin
          next_bus       = BUS_FREE;
          next_ack_drive = 1'b0;
          if (count != 8'h00 && {1'b0, wr_ptr} >= count) begin
            next_pwr   = PWR_BUSY;
            next_timer = '0;
          end
        end else if (bus != BUS_FREE && bus != BUS_SKIP) begin
          if (scl_fall && ack_phase) begin
            // Release after the ninth clock
            next_ack_phase = 1'b0;
            next_ack_drive = 1'b0;
            if (bus == BUS_READ) begin
              next_bus = BUS_SKIP;
            end
          end else if (scl_fall && bit_cnt == 4'd8) begin
            // Decide the ninth-clock answer on the eighth fall
            next_bit_cnt   = '0;
            next_ack_phase = 1'b1;
            case (bus)
              BUS_ADDR: begin
                if (shift[7:1] != bus_address_in) begin
                  next_bus = BUS_SKIP;
                end else if (!shift[0]) begin
                  accept   = 1'b1;
                  next_bus = BUS_WORD;
                end else begin
                  // Read with an unfinished command gets no answer
                  accept   = (count == 8'h00);
                  next_bus = accept ? BUS_READ : BUS_SKIP;
                end
              end
              BUS_WORD: begin
                accept = 1'b1;
                case (shift)
                  `WA_RESET:   next_wr_ptr = '0;
                  `WA_SLEEP:   next_bus = BUS_FREE;
                  `WA_IDLE:    next_bus = BUS_FREE;
                  `WA_COMMAND: next_bus = BUS_DATA;
                  default:     accept = 1'b0;
                endcase
                // Power leaves READY at this edge, so an ack would be cut short
                if (shift == `WA_SLEEP) begin
                  accept      = 1'b0;
                  next_pwr    = PWR_SLEEP;
                  next_wr_ptr = '0;
                  next_count  = '0;
                  next_keep   = 1'b0;
                  next_timer  = '0;
                end else if (shift == `WA_IDLE) begin
                  accept      = 1'b0;
                  next_pwr    = PWR_IDLE;
                  next_wr_ptr = '0;
                  next_count  = '0;
                  next_keep   = 1'b1;
                  next_timer  = '0;
                end
              end
              BUS_DATA: begin
                // Past count or buffer end the byte is refused
                if (wr_ptr == 7'(BUF_DEPTH)) begin
                  accept = 1'b0;
                end else if (wr_ptr == '0) begin
                  accept     = 1'b1;
                  next_count = shift;
                end else begin
                  accept = ({1'b0, wr_ptr} < count);
                end
                if (accept) begin
                  wr_en       = 1'b1;
                  next_wr_ptr = wr_ptr + 7'd1;
                end
              end
              default: accept = 1'b0;
            endcase
            next_ack_drive = accept;
          end else if (scl_rise && !ack_phase && bus != BUS_READ) begin
            next_shift   = byte_now;
            next_bit_cnt = bit_cnt + 4'd1;
          end
        end
      end
      default: begin
        next_pwr = PWR_SLEEP;
        next_bus = BUS_FREE;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr       <= PWR_SLEEP;
      bus       <= BUS_FREE;
      timer     <= '0;
      bit_cnt   <= '0;
      shift     <= 8'h00;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
      wr_ptr    <= '0;
      count     <= 8'h00;
      keep      <= 1'b0;
    end else begin
      pwr       <= next_pwr;
      bus       <= next_bus;
      timer     <= next_timer;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      ack_phase <= next_ack_phase;
      ack_drive <= next_ack_drive;
      wr_ptr    <= next_wr_ptr;
      count     <= next_count;
      keep      <= next_keep;
    end
  end

  // Buffer storage, one flop byte per entry
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
    logic [7:0] next_entry;
    always_comb begin
      next_entry = buffer[i];
      if (wr_en && wr_ptr == 7'(i)) begin
        next_entry = shift;
      end
    end
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        buffer[i] <= 8'h00;
      end else begin
        buffer[i] <= next_entry;
      end
    end
    assign buf_data_out[i] = buffer[i];
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out           = 1'b0;
  assign sda_oe_out        = ack_drive;
  assign buf_fill_out      = wr_ptr;
  assign awake_out         = (pwr == PWR_READY) || (pwr == PWR_BUSY);
  assign busy_out          = (pwr == PWR_BUSY);
  assign keep_key_seed_out = keep;

endmodule : se_i2c_target

//--- dv/se_i2c_props.sv
// Checker for the two-wire target port.
// Assumes binding to se_i2c_target, one clock domain.
`timescale 1ns/10ps
module se_i2c_props
  import se_i2c_pkg::*;
#(
  parameter int EXEC_CYCLES = 50,
  parameter int BUF_DEPTH   = 71
) (
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [6:0] buf_fill_out,
  input wire logic       awake_out,
  input wire logic       busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  int busy_len;
  int next_busy_len;
  // Busy run length; zero outside execution
  always_comb next_busy_len = busy_out ? busy_len + 1 : 0;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) busy_len <= 0;
    else busy_len <= next_busy_len;
  end
  sequence s_ack_on; $rose(sda_oe_out); endsequence
  sequence s_ack_hold; sda_oe_out [*6]; endsequence
  a_pull_only: assert property (sda_out == 1'b0)
    else $error("data driven high");
  a_ack_scl_low: assert property (s_ack_on |-> !$past(scl_in))
    else $error("ack changed with clock high");
  a_ack_held: assert property (s_ack_on |-> s_ack_hold)
    else $error("ack dropped early");
  a_ack_release: assert property (s_ack_on |-> ##[6:24] !sda_oe_out)
    else $error("ack held too long");
  a_ack_awake: assert property (s_ack_on |-> awake_out && !busy_out)
    else $error("ack while not ready");
  a_busy_fill: assert property ($rose(busy_out) |-> buf_fill_out != 7'h00)
    else $error("busy with empty buffer");
  a_exec_len: assert property ($fell(busy_out) |->
    busy_len inside {[EXEC_CYCLES-1:EXEC_CYCLES+1]})
    else $error("execution length wrong");
  a_fill_clear: assert property ($fell(busy_out) |-> ##[0:2] buf_fill_out == 7'h00)
    else $error("buffer not cleared");
  a_fill_bound: assert property (buf_fill_out <= BUF_DEPTH)
    else $error("buffer overrun");
  a_busy_awake: assert property (busy_out |-> awake_out)
    else $error("busy while asleep");
endmodule : se_i2c_props

bind se_i2c_target se_i2c_props #(.EXEC_CYCLES(EXEC_CYCLES), .BUF_DEPTH(BUF_DEPTH)) u_props (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .buf_fill_out(buf_fill_out), .awake_out(awake_out),
  .busy_out(busy_out));

//--- dv/se_i2c_host_model.sv
// Bus controller model: clock pin and open-drain data pull.
// Assumes a pull-up on the data wire; clock idles high.
`timescale 1ns/10ps
module se_i2c_host_model
  import se_i2c_pkg::*;
(
  // Bus pins
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Data moves mid low phase only
  task automatic bit_tx(input logic b, output logic s);
    #40 sda_out = b;
    #40 scl_out = 1'b1;
    #40 s = sda_in;
    #40 scl_out = 1'b0;
  endtask : bit_tx
  task automatic start();
    // Release data a phase before the clock rises: a late ack release is no stop
    #40 sda_out = 1'b1;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask : start
  task automatic stop();
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b1;
    #40;
  endtask : stop
  // MSB first, ninth clock released to read the ack
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_tx(b[i], s);
    bit_tx(1'b1, s);
    ack = ~s;
  endtask : byte_tx
  task automatic wake(input int ns);
    sda_out = 1'b0;
    #(ns) sda_out = 1'b1;
  endtask : wake
endmodule : se_i2c_host_model

//--- dv/se_i2c_target_tb_top.sv
// Bench for the target port: wake, commands, word addresses.
// Assumes the host model on the bus and a pull-up on data.
`timescale 1ns/10ps
`include "se_i2c_regs.svh"
module se_i2c_target_tb_top
  import se_i2c_pkg::*;
;
  localparam int WL = 100; // Longer than any low run of a byte at the bench rate
  localparam int WR = 40;
  localparam int EX = 400; // Outlasts one refused read poll
  localparam int DEP = 71;
  logic       clk_sys_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [6:0] bus_address_in = 7'h60;
  logic       scl, sda_drv, sda_out, sda_oe_out, awake_out, busy_out, keep;
  logic [7:0] buf_data_out [DEP];
  logic [6:0] buf_fill_out;
  logic [7:0] d [DEP+1];
  logic [7:0] adr;
  logic [15:0] cs;
  int         miscompares = 0;
  int         n_tests = 0;
  int         n;
  // Wired-and with pull-up
  wire        sda_w = sda_drv & ~(sda_oe_out & ~sda_out);
  always #10 clk_sys_in = ~clk_sys_in;
  se_i2c_target #(.WAKE_LOW_CYCLES(WL), .WAKE_READY_CYCLES(WR), .EXEC_CYCLES(EX),
    .BUF_DEPTH(DEP)) uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .bus_address_in(bus_address_in), .buf_data_out(buf_data_out),
    .buf_fill_out(buf_fill_out), .awake_out(awake_out), .busy_out(busy_out),
    .keep_key_seed_out(keep));
  se_i2c_host_model h (.scl_out(scl), .sda_out(sda_drv), .sda_in(sda_w));
  // Count byte always taken; others inside count and buffer
  function automatic logic exp_ack(input int i, input int c);
    return (i < DEP) && (i == 0 || i < c);
  endfunction : exp_ack
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic sb(input logic [7:0] b, input logic e);
    logic k;
    h.byte_tx(b, k);
    check(k, e);
  endtask : sb
  // Settle after stop so flags are read stable
  task automatic sp();
    h.stop();
    repeat (10) @(negedge clk_sys_in);
  endtask : sp
  task automatic wake();
    h.wake((WL + 10) * 20);
    repeat (WR + 10) @(negedge clk_sys_in);
  endtask : wake
  task automatic wt(input logic v);
    for (int i = 0; i < EX + 20 && busy_out !== v; i++) @(negedge clk_sys_in);
  endtask : wt
  task automatic wrap_up();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #1_500_000;
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(95781));
    bus_address_in = 7'($urandom);
    adr = {bus_address_in, 1'b0};
    repeat (8) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    // Asleep: traffic and clock edges get no answer
    h.start();
    sb(adr, 1'b0);
    sp();
    check(awake_out, 1'b0);
    wake();
    check(awake_out, 1'b1);
    h.start();
    sb(adr ^ {7'($urandom % 127 + 1), 1'b0}, 1'b0);
    sp();
    // Command over two transfers, a wake in between
    n = 3 + $urandom % 6;
    foreach (d[i]) d[i] = 8'($urandom);
    d[0] = 8'(n);
    cs = 16'h0000;
    for (int i = 0; i < n - 2; i++) cs = cs + 16'(d[i]);
    {d[n-2], d[n-1]} = cs;
    h.start();
    sb(adr, 1'b1);
    sb(`WA_COMMAND, 1'b1);
    for (int i = 0; i < 2; i++) sb(d[i], 1'b1);
    sp();
    wake();
    check(awake_out, 1'b1);
    check(buf_fill_out, 8'h02);
    h.start();
    sb(adr, 1'b1);
    sb(`WA_COMMAND, 1'b1);
    for (int i = 2; i <= n; i++) sb(d[i], exp_ack(i, n));
    h.stop();
    for (int i = 0; i < n; i++) check(buf_data_out[i], d[i]);
    wt(1'b1);
    check(busy_out, 1'b1);
    h.start();
    sb(adr | 8'h01, 1'b0);
    h.stop();
    wt(1'b0);
    check(buf_fill_out, 8'h00);
    h.start();
    sb(adr | 8'h01, 1'b1);
    sp();
    // Counter reset, then a count past the buffer end
    h.start();
    sb(adr, 1'b1);
    sb(`WA_COMMAND, 1'b1);
    sb(8'h05, 1'b1);
    h.start();
    sb(adr, 1'b1);
    sb(`WA_RESET, 1'b1);
    sp();
    check(buf_fill_out, 8'h00);
    d[0] = 8'h50;
    h.start();
    sb(adr, 1'b1);
    sb(`WA_COMMAND, 1'b1);
    for (int i = 0; i <= DEP; i++) sb(d[i], exp_ack(i, 8'h50));
    sp();
    check(busy_out, 1'b0);
    check(buf_data_out[0], 8'h50);
    for (int i = 0; i < 3; i++) begin
      h.start();
      sb(adr, 1'b1);
      sb(8'(4 + $urandom % 252), 1'b0);
      sp();
    end
    check(buf_fill_out, 8'h47);
    h.start();
    sb(adr, 1'b1);
    sb(`WA_SLEEP, 1'b0);
    sp();
    check({6'h00, awake_out, keep}, 8'h00);
    check({1'b0, buf_fill_out}, 8'h00);
    wake();
    h.start();
    sb(adr, 1'b1);
    sb(`WA_IDLE, 1'b0);
    sp();
    check({awake_out, keep}, 8'h01);
    h.start();
    sb(adr | 8'h01, 1'b0);
    sp();
    wrap_up();
  end
endmodule : se_i2c_target_tb_top
